// ===== verilog/epi_pkg.sv
// package: register map, field positions and encodings of the external pin interrupt unit
package epi_pkg;
	// ************************************************************
	// register byte addresses
	// ************************************************************
	localparam logic [7:0] ADDR_SENSE = 8'h00;
	localparam logic [7:0] ADDR_ENABLE = 8'h04;
	localparam logic [7:0] ADDR_FLAGS = 8'h08;
	localparam logic [7:0] ADDR_MASK_LO = 8'h0c;
	localparam logic [7:0] ADDR_MASK_HI = 8'h10;
	localparam logic [7:0] ADDR_CORE = 8'h14;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
	localparam logic [7:0] ADDR_PINS = 8'h1c;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int BIT_UPPER = 7;
	localparam int BIT_LOWER = 6;
	localparam int BIT_PIN = 0;
	localparam int BIT_GLOBAL = 7;
	localparam logic [7:0] FLAG_BITS = 8'h c1;

	// ************************************************************
	// reset values and bus answers
	// ************************************************************
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		EPI_SENSE_LOW = 2'h0,
		EPI_SENSE_ANY = 2'h1,
		EPI_SENSE_FALL = 2'h2,
		EPI_SENSE_RISE = 2'h3
	} epi_sense_t;

	// bus slave states, two only: idle -> answer
	typedef enum logic [1:0] {
		EPI_IDLE = 2'h0,
		EPI_RESP = 2'h1
	} epi_bus_t;
endpackage

// ===== verilog/epi_unit.sv
// module: external pin interrupt unit with AXI4-Lite register slave
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module epi_unit (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic dedicated_irq_pin,
	input wire logic [15:0] change_inputs,
	input wire logic [2:0] vector_ack,
	output logic [2:0] core_request,
	output logic irq,
	output logic wake_request
);
	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic [1:0] sense;
		logic [7:0] enable;
		logic [7:0] flags;
		logic [7:0] mask_lo;
		logic [7:0] mask_hi;
		logic [7:0] core_status;
		logic [7:0] irq_mask;
		// two pin samples: edges are found between them, never on the raw pin
		logic pin_q;
		logic pin_qq;
		logic [15:0] chg_q;
		logic primed;
		logic primed2;
		epi_pkg::epi_bus_t wst;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic wbyte0;
		logic [1:0] bresp;
		epi_pkg::epi_bus_t rst;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} epi_state_t;

	epi_state_t q;
	epi_state_t next_q;

	logic pin_rise;
	logic pin_fall;
	logic pin_evt;
	logic [2:0] raw_request;
	logic upper_wake;
	logic lower_wake;
	logic upper_evt;
	logic lower_evt;
	logic level_mode;
	logic [7:0] flags_view;
	logic [7:0] evt_bits;
	logic [7:0] clr_bits;
	logic [31:0] rd_val;
	logic rd_ok;
	logic wr_ok;
	logic do_write;

	// ************************************************************
	// detection
	// ************************************************************
	assign level_mode = (q.sense == epi_pkg::EPI_SENSE_LOW);
	// edges compare two registered samples: a pulse held over one full edge is caught
	// costs one cycle of latency, but a glitch between edges can never raise a flag
	assign pin_rise = q.primed2 && q.pin_q && !q.pin_qq;
	assign pin_fall = q.primed2 && !q.pin_q && q.pin_qq;
	always_comb begin
		case (q.sense)
			epi_pkg::EPI_SENSE_ANY: pin_evt = pin_rise || pin_fall;
			epi_pkg::EPI_SENSE_FALL: pin_evt = pin_fall;
			epi_pkg::EPI_SENSE_RISE: pin_evt = pin_rise;
			default: pin_evt = 1'b0;
		endcase
	end
	// inputs are read whatever drives them, so software-driven pins also count
	// one detector per group; flags use the masked toggle, wake the same compare unclocked
	epi_group_detect #(
		.WIDTH(8)
	) upper_u (
		.primed(q.primed),
		.group_enable(q.enable[epi_pkg::BIT_UPPER]),
		.pins(change_inputs[15:8]),
		.sampled(q.chg_q[15:8]),
		.mask(q.mask_hi),
		.event_seen(upper_evt),
		.wake_seen(upper_wake)
	);
	epi_group_detect #(
		.WIDTH(8)
	) lower_u (
		.primed(q.primed),
		.group_enable(q.enable[epi_pkg::BIT_LOWER]),
		.pins(change_inputs[7:0]),
		.sampled(q.chg_q[7:0]),
		.mask(q.mask_lo),
		.event_seen(lower_evt),
		.wake_seen(lower_wake)
	);

	always_comb begin
		evt_bits = 8'h00;
		evt_bits[epi_pkg::BIT_UPPER] = upper_evt;
		evt_bits[epi_pkg::BIT_LOWER] = lower_evt;
		evt_bits[epi_pkg::BIT_PIN] = pin_evt;
	end

	// level mode: pin flag held clear; request is the live low level
	always_comb begin
		flags_view = q.flags & epi_pkg::FLAG_BITS;
		if (level_mode) begin
			flags_view[epi_pkg::BIT_PIN] = 1'b0;
		end
	end

	// ************************************************************
	// core requests and wake
	// ************************************************************
	always_comb begin
		raw_request[2] = flags_view[epi_pkg::BIT_UPPER] && q.enable[epi_pkg::BIT_UPPER];
		raw_request[1] = flags_view[epi_pkg::BIT_LOWER] && q.enable[epi_pkg::BIT_LOWER];
		if (level_mode) begin
			// held low must outlast the instruction and start-up; the source ensures it
			raw_request[0] = !dedicated_irq_pin && q.enable[epi_pkg::BIT_PIN];
		end else begin
			raw_request[0] = flags_view[epi_pkg::BIT_PIN] && q.enable[epi_pkg::BIT_PIN];
		end
		// the global bit gates all three, so software holds off every core request at once
		core_request = raw_request & {3{q.core_status[epi_pkg::BIT_GLOBAL]}};
	end

	// wake is pure combinational so it works with the clock stopped
	always_comb begin
		wake_request = 1'b0;
		if (level_mode && q.enable[epi_pkg::BIT_PIN] && !dedicated_irq_pin) begin
			wake_request = 1'b1;
		end
		if (upper_wake || lower_wake) begin
			wake_request = 1'b1;
		end
	end

	assign irq = |(flags_view & q.irq_mask);

	// ************************************************************
	// register bus
	// ************************************************************
	always_comb begin
		rd_ok = 1'b1;
		case (s_axi_araddr)
			epi_pkg::ADDR_SENSE: rd_val = {30'h0000_0000, q.sense};
			epi_pkg::ADDR_ENABLE: rd_val = {24'h00_0000, q.enable & epi_pkg::FLAG_BITS};
			epi_pkg::ADDR_FLAGS: rd_val = {24'h00_0000, flags_view};
			epi_pkg::ADDR_MASK_LO: rd_val = {24'h00_0000, q.mask_lo};
			epi_pkg::ADDR_MASK_HI: rd_val = {24'h00_0000, q.mask_hi};
			epi_pkg::ADDR_CORE: rd_val = {24'h00_0000, q.core_status};
			epi_pkg::ADDR_IRQ_MASK: rd_val = {24'h00_0000, q.irq_mask & epi_pkg::FLAG_BITS};
			epi_pkg::ADDR_PINS: rd_val = {15'h0000, dedicated_irq_pin, change_inputs};
			default: begin
				rd_val = 32'h0000_0000;
				rd_ok = 1'b0;
			end
		endcase
	end

	assign s_axi_awready = (q.wst == epi_pkg::EPI_IDLE) && !q.aw_got;
	assign s_axi_wready = (q.wst == epi_pkg::EPI_IDLE) && !q.w_got;
	assign s_axi_bvalid = (q.wst == epi_pkg::EPI_RESP);
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = (q.rst == epi_pkg::EPI_IDLE);
	assign s_axi_rvalid = (q.rst == epi_pkg::EPI_RESP);
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;

	always_comb begin
		wr_ok = 1'b0;
		case (q.awaddr)
			epi_pkg::ADDR_SENSE, epi_pkg::ADDR_ENABLE, epi_pkg::ADDR_FLAGS,
			epi_pkg::ADDR_MASK_LO, epi_pkg::ADDR_MASK_HI, epi_pkg::ADDR_CORE,
			epi_pkg::ADDR_IRQ_MASK, epi_pkg::ADDR_PINS: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end
	assign do_write = (q.wst == epi_pkg::EPI_IDLE) && q.aw_got && q.w_got && q.wbyte0;

	always_comb begin
		clr_bits = 8'h00;
		if (do_write && q.awaddr == epi_pkg::ADDR_FLAGS) begin
			clr_bits = q.wdata[7:0];
		end
		clr_bits[epi_pkg::BIT_UPPER] = clr_bits[epi_pkg::BIT_UPPER] || vector_ack[2];
		clr_bits[epi_pkg::BIT_LOWER] = clr_bits[epi_pkg::BIT_LOWER] || vector_ack[1];
		clr_bits[epi_pkg::BIT_PIN] = clr_bits[epi_pkg::BIT_PIN] || vector_ack[0];
	end

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		next_q = q;
		next_q.pin_q = dedicated_irq_pin;
		next_q.chg_q = change_inputs;
		next_q.pin_qq = q.pin_q;
		next_q.primed = 1'b1;
		// second sample is only valid one edge after the first
		next_q.primed2 = q.primed;
		// a new event wins over a clear in the same cycle
		next_q.flags = ((q.flags & ~clr_bits) | evt_bits) & epi_pkg::FLAG_BITS;
		if (level_mode) begin
			next_q.flags[epi_pkg::BIT_PIN] = 1'b0;
		end

		if (s_axi_awvalid && s_axi_awready) begin
			next_q.aw_got = 1'b1;
			next_q.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_q.w_got = 1'b1;
			next_q.wdata = s_axi_wdata;
			next_q.wbyte0 = s_axi_wstrb[0];
		end
		case (q.wst)
			epi_pkg::EPI_IDLE: begin
				if (q.aw_got && q.w_got) begin
					next_q.wst = epi_pkg::EPI_RESP;
					next_q.bresp = wr_ok ? epi_pkg::RESP_OKAY : epi_pkg::RESP_SLVERR;
					next_q.aw_got = 1'b0;
					next_q.w_got = 1'b0;
					if (q.wbyte0) begin
						case (q.awaddr)
							epi_pkg::ADDR_SENSE: next_q.sense = q.wdata[1:0];
							epi_pkg::ADDR_ENABLE: next_q.enable = q.wdata[7:0] & epi_pkg::FLAG_BITS;
							epi_pkg::ADDR_MASK_LO: next_q.mask_lo = q.wdata[7:0];
							epi_pkg::ADDR_MASK_HI: next_q.mask_hi = q.wdata[7:0];
							epi_pkg::ADDR_CORE: next_q.core_status = q.wdata[7:0];
							epi_pkg::ADDR_IRQ_MASK: next_q.irq_mask = q.wdata[7:0] & epi_pkg::FLAG_BITS;
							default: next_q.sense = next_q.sense;
						endcase
					end
				end
			end
			epi_pkg::EPI_RESP: begin
				if (s_axi_bready) begin
					next_q.wst = epi_pkg::EPI_IDLE;
				end
			end
			default: next_q.wst = epi_pkg::EPI_IDLE;
		endcase

		case (q.rst)
			epi_pkg::EPI_IDLE: begin
				if (s_axi_arvalid) begin
					next_q.rst = epi_pkg::EPI_RESP;
					next_q.rdata = rd_val;
					next_q.rresp = rd_ok ? epi_pkg::RESP_OKAY : epi_pkg::RESP_SLVERR;
				end
			end
			epi_pkg::EPI_RESP: begin
				if (s_axi_rready) begin
					next_q.rst = epi_pkg::EPI_IDLE;
				end
			end
			default: next_q.rst = epi_pkg::EPI_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end
endmodule

// ************************************************************
// pin-change group detector
// ************************************************************
// one group of change inputs: masked toggle for the flag, same compare for wake
module epi_group_detect #(
	parameter int WIDTH = 8
) (
	input wire logic primed,
	input wire logic group_enable,
	input wire logic [WIDTH-1:0] pins,
	input wire logic [WIDTH-1:0] sampled,
	input wire logic [WIDTH-1:0] mask,
	output logic event_seen,
	output logic wake_seen
);
	logic [WIDTH-1:0] diff;

	// the compare needs no clock edge, so wake works while the clock is stopped
	assign diff = (pins ^ sampled) & mask;
	// flags ignore the first edge after reset, when the sample is not yet valid
	assign event_seen = primed && (|diff);
	// the group enable gates only wake and request, never the flag
	assign wake_seen = group_enable && (|diff);
endmodule

`default_nettype wire

// ===== tb/epi_asserts.sv
// checker: port-level assertions for the external pin interrupt unit
`timescale 1ns/1ps
`default_nettype none
module epi_asserts (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic dedicated_irq_pin,
	input wire logic [15:0] change_inputs,
	input wire logic [2:0] vector_ack,
	input wire logic [2:0] core_request
);
	logic [7:0] wa, wd, ra;
	logic [1:0] sense;
	logic en0, glob;
	logic armed;
	// shadow lags the register by the response phase, so the armed and ack checks skip while bvalid
	always_ff @(posedge aclk) begin
		if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[7:0];
		if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
		if (!aresetn) {sense, en0, glob} <= 4'h0;
		else if (s_axi_bvalid && s_axi_bready) begin
			if (wa == epi_pkg::ADDR_SENSE) sense <= wd[1:0];
			if (wa == epi_pkg::ADDR_ENABLE) en0 <= wd[0];
			if (wa == epi_pkg::ADDR_CORE) glob <= wd[7];
		end
	end
	assign armed = en0 && glob && !s_axi_bvalid;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	lvl_req_a: assert property (armed && sense == 2'h0 |-> core_request[0] == !dedicated_irq_pin)
		else $error("level request does not follow pin");
	lvl_flag_a: assert property (s_axi_rvalid && ra == epi_pkg::ADDR_FLAGS && sense == 2'h0
		|-> !s_axi_rdata[0]) else $error("pin flag seen in level mode");
	edge_req_a: assert property (armed && $changed(dedicated_irq_pin) && (sense == 2'h1
		|| sense[1] && sense[0] == dedicated_irq_pin) |-> ##2 core_request[0]) else $error("edge lost");
	edge_none_a: assert property ($stable(dedicated_irq_pin) ##1 (armed && sense[1]
		&& $changed(dedicated_irq_pin) && sense[0] != dedicated_irq_pin && !core_request[0])
		|=> ##1 !core_request[0]) else $error("wrong edge raised request");
	ack_clr_a: assert property ($stable(dedicated_irq_pin) ##1 (!s_axi_bvalid && sense != 2'h0
		&& vector_ack[0] && $stable(dedicated_irq_pin)) |=> !core_request[0])
		else $error("pin flag kept after entry");
	grp_clr_a: assert property (vector_ack[2] && $stable(change_inputs[15:8])
		|=> !core_request[2]) else $error("upper flag kept after entry");
endmodule
`default_nettype wire

// ===== tb/epi_src.sv
// partner: behavioural sources driving the interrupt pin and change inputs
`timescale 1ns/1ps
`default_nettype none
module epi_src (
	input wire logic aclk,
	output logic dedicated_irq_pin,
	output logic [15:0] change_inputs
);
	initial begin
		dedicated_irq_pin = 1'b1;
		change_inputs = 16'h0000;
	end
	// the level stays for hold edges, so a slow source keeps it past start-up
	task automatic drive(input logic p, input logic [15:0] c, input int hold);
		@(posedge aclk);
		dedicated_irq_pin <= p;
		change_inputs <= c;
		repeat (hold) @(posedge aclk);
	endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// testbench: register, pin and pin-change scenarios for the external pin interrupt unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [2:0] vector_ack = 3'h0;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic dedicated_irq_pin, irq, wake_request;
	wire logic [15:0] change_inputs;
	wire logic [2:0] core_request;
	int fails = 0, n_checks = 0;
	always #2.5 aclk = ~aclk;
	epi_src src_u (.*);
	epi_unit dut_u (.*);
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// handshakes are judged at the falling edge, where nothing is moving
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw, tb = 1'b0;
		int n = 0;
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		while (!tb && n < 50) begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready === 1'b1;
			tw = s_axi_wvalid && s_axi_wready === 1'b1;
			tb = s_axi_bvalid === 1'b1;
			if (tb) chk("bresp", 32'(er), 32'(s_axi_bresp));
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			n++;
		end
		s_axi_bready <= 1'b0;
		if (!tb) fails++;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ta, tr = 1'b0;
		int n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		while (!tr && n < 50) begin
			@(negedge aclk);
			ta = s_axi_arvalid && s_axi_arready === 1'b1;
			tr = s_axi_rvalid === 1'b1;
			if (tr) chk("rdata", ed, s_axi_rdata);
			if (tr) chk("rresp", 32'(er), 32'(s_axi_rresp));
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
			n++;
		end
		s_axi_rready <= 1'b0;
		if (!tr) fails++;
	endtask
	task automatic ack(input logic [2:0] v);
		@(posedge aclk);
		vector_ack <= v;
		@(posedge aclk);
		vector_ack <= 3'h0;
		@(negedge aclk);
		chk("core_request", 32'h0, 32'(core_request));
	endtask
	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_regs;
		for (int i = 0; i < 7; i++) rd(8'(4 * i), 32'h0, 2'h0);
		rd(epi_pkg::ADDR_PINS, 32'h0001_0000, 2'h0);
		rd(8'h20, 32'h0, epi_pkg::RESP_SLVERR);
		wr(8'h20, 32'h0000_00ff, epi_pkg::RESP_SLVERR);
		wr(epi_pkg::ADDR_MASK_HI, 32'h0000_005a, 2'h0);
		rd(epi_pkg::ADDR_MASK_HI, 32'h0000_005a, 2'h0);
		s_axi_wstrb <= 4'h0;
		wr(epi_pkg::ADDR_MASK_HI, 32'h0000_00ff, epi_pkg::RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		rd(epi_pkg::ADDR_MASK_HI, 32'h0000_005a, 2'h0);
	endtask
	task automatic t_level;
		wr(epi_pkg::ADDR_ENABLE, 32'h0000_0001, 2'h0);
		wr(epi_pkg::ADDR_CORE, 32'h0000_0080, 2'h0);
		src_u.drive(1'b0, change_inputs, 3);
		@(negedge aclk);
		chk("core_request", 32'h1, 32'(core_request));
		chk("wake_request", 32'h1, 32'(wake_request));
		rd(epi_pkg::ADDR_FLAGS, 32'h0, 2'h0);
		src_u.drive(1'b1, change_inputs, 2);
		@(negedge aclk);
		chk("core_request", 32'h0, 32'(core_request));
	endtask
	task automatic t_edge;
		for (int m = 1; m < 4; m++) begin
			wr(epi_pkg::ADDR_SENSE, 32'(m), 2'h0);
			wr(epi_pkg::ADDR_FLAGS, 32'h0000_0001, 2'h0);
			src_u.drive(1'b0, change_inputs, 3);
			rd(epi_pkg::ADDR_FLAGS, 32'(m != 3), 2'h0);
			@(negedge aclk);
			chk("core_request", 32'(m != 3), 32'(core_request));
			wr(epi_pkg::ADDR_FLAGS, 32'h0, 2'h0);
			rd(epi_pkg::ADDR_FLAGS, 32'(m != 3), 2'h0);
			wr(epi_pkg::ADDR_FLAGS, 32'h0000_0001, 2'h0);
			src_u.drive(1'b1, change_inputs, 3);
			rd(epi_pkg::ADDR_FLAGS, 32'(m != 2), 2'h0);
			ack(3'h1);
		end
	endtask
	task automatic t_change;
		wr(epi_pkg::ADDR_MASK_HI, 32'h0000_0001, 2'h0);
		wr(epi_pkg::ADDR_MASK_LO, 32'h0000_0080, 2'h0);
		wr(epi_pkg::ADDR_ENABLE, 32'h0000_00c0, 2'h0);
		wr(epi_pkg::ADDR_IRQ_MASK, 32'h0000_0080, 2'h0);
		src_u.drive(1'b1, 16'h0200, 3);
		rd(epi_pkg::ADDR_FLAGS, 32'h0, 2'h0);
		src_u.drive(1'b1, 16'h0300, 0);
		@(negedge aclk);
		chk("wake_request", 32'h1, 32'(wake_request));
		rd(epi_pkg::ADDR_FLAGS, 32'h0000_0080, 2'h0);
		@(negedge aclk);
		chk("core_request", 32'h4, 32'(core_request));
		chk("irq", 32'h1, 32'(irq));
		wr(epi_pkg::ADDR_IRQ_MASK, 32'h0, 2'h0);
		@(negedge aclk);
		chk("irq", 32'h0, 32'(irq));
		ack(3'h4);
		src_u.drive(1'b1, 16'h0380, 3);
		rd(epi_pkg::ADDR_FLAGS, 32'h0000_0040, 2'h0);
		@(negedge aclk);
		chk("core_request", 32'h2, 32'(core_request));
		wr(epi_pkg::ADDR_CORE, 32'h0, 2'h0);
		@(negedge aclk);
		chk("core_request", 32'h0, 32'(core_request));
	endtask
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs;
		t_level;
		t_edge;
		t_change;
		conclude;
	end
	initial begin
		repeat (20000) @(posedge aclk);
		fails++;
		conclude;
	end
endmodule
bind epi_unit epi_asserts chk_u (.*);
`default_nettype wire
